// ### core/aabs_pkg.sv
package aabs_pkg;

  localparam int ACC_W = 36;
  localparam int WORD_W = 16;
  localparam int EXT_W = 4;
  localparam int BYTE_W = 8;
  localparam int SAMT_W = 7;
  localparam int HI_LSB = 16;
  localparam int EXT_LSB = 32;
  localparam logic [ACC_W-1:0] ROUND_CONST = 36'h0_0000_8000;
  localparam logic signed [SAMT_W-1:0] SHV_MAX = 7'sd36;
  localparam logic signed [SAMT_W-1:0] SHV_MIN = -7'sd36;
  localparam logic signed [SAMT_W-1:0] ONE_BIT = 7'sd1;
  localparam logic signed [SAMT_W-1:0] FOUR_BIT = 7'sd4;

  // Operations issued by the decoder.
  typedef enum logic [4:0] {
    OP_NOP     = 5'h00,
    OP_LOAD    = 5'h01,
    OP_LOAD_HI = 5'h02,
    OP_LOAD_LO = 5'h03,
    OP_LOAD_EX = 5'h04,
    OP_ADD     = 5'h05,
    OP_SUB     = 5'h06,
    OP_CMP     = 5'h07,
    OP_AND     = 5'h08,
    OP_OR      = 5'h09,
    OP_XOR     = 5'h0A,
    OP_ROUND   = 5'h0B,
    OP_MAX     = 5'h0C,
    OP_MIN     = 5'h0D,
    OP_MAXMEM  = 5'h0E,
    OP_SHIFT_I = 5'h0F,
    OP_SHIFT_R = 5'h10,
    OP_MOD_SHL1 = 5'h11,
    OP_MOD_SHR1 = 5'h12,
    OP_MOD_ROL1 = 5'h13,
    OP_MOD_ROR1 = 5'h14,
    OP_MOD_SHL4 = 5'h15,
    OP_MOD_SHR4 = 5'h16,
    OP_SWAP    = 5'h17,
    OP_ADD_RMW = 5'h18,
    OP_SUB_RMW = 5'h19,
    OP_CMP_RMW = 5'h1A,
    OP_ROTATE  = 5'h1B
  } aabs_op_t;

  // Second-operand source.
  typedef enum logic [1:0] {
    SRC_BUS  = 2'h0,
    SRC_PROD = 2'h1,
    SRC_ACC  = 2'h2
  } aabs_src_t;

  // Width of a bus operand.
  typedef enum logic [1:0] {
    SZ_8  = 2'h0,
    SZ_16 = 2'h1,
    SZ_36 = 2'h2
  } aabs_size_t;

  // One instruction presented by the decoder.
  typedef struct packed {
    logic                     valid;
    aabs_op_t                 op;
    logic [1:0]               dst;
    logic [1:0]               src_acc;
    aabs_src_t                src2;
    aabs_size_t               size;
    logic                     no_ext;
    logic                     or_equal;
    logic                     cond;
    logic                     round_par;
    logic signed [5:0]        imm_shift;
    logic [WORD_W-1:0]        imm;
  } aabs_cmd_t;

  // Status flags.
  typedef struct packed {
    logic z;
    logic m;
    logic n;
    logic e;
    logic c;
  } aabs_flags_t;

endpackage

// ### core/aabs_shifter.sv
`timescale 1ns/1ns
// Combinational 36-bit barrel shifter.
module aabs_shifter
  import aabs_pkg::*;
(
  input  wire logic [ACC_W-1:0]         din,
  input  wire logic signed [SAMT_W-1:0] amt,
  input  wire logic                     arith,
  input  wire logic                     rotate,
  output logic [ACC_W-1:0]              dout,
  output logic                          cout
);

  // Positive amounts go left, negative go right; overlong amounts saturate.
  always_comb
  begin
    logic [2*ACC_W-1:0] wide;
    logic [SAMT_W-1:0]  mag;
    wide = '0;
    mag = amt[SAMT_W-1] ? SAMT_W'(-amt) : amt;
    if (mag > SAMT_W'(ACC_W))
    begin
      mag = SAMT_W'(ACC_W);
    end
    if (rotate)
    begin
      wide = {din, din};
      if (amt[SAMT_W-1])
      begin
        wide = wide >> (mag % ACC_W);
      end
      else
      begin
        wide = wide << (mag % ACC_W);
      end
      dout = amt[SAMT_W-1] ? wide[ACC_W-1:0] : wide[2*ACC_W-1:ACC_W];
      cout = amt[SAMT_W-1] ? dout[ACC_W-1] : dout[0];
    end
    else if (!amt[SAMT_W-1])
    begin
      wide = {{ACC_W{1'b0}}, din} << mag;
      dout = wide[ACC_W-1:0];
      cout = (mag != '0) && wide[ACC_W];
    end
    else
    begin
      wide = {din, {ACC_W{1'b0}}};
      // Inverting around a zero-filling shift replicates a negative sign bit.
      wide = (arith && din[ACC_W-1]) ? ~((~wide) >> mag) : (wide >> mag);
      dout = wide[2*ACC_W-1:ACC_W];
      cout = (mag != '0) && wide[ACC_W-1];
    end
  end

endmodule

// ### core/aabs_datapath.sv
`timescale 1ns/1ns
// Accumulators, ALU, max/min search and shifter control of the core.
module aabs_datapath
  import aabs_pkg::*;
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST,
  input  wire aabs_cmd_t                CMD,
  input  wire logic [WORD_W-1:0]        BUS_IN,
  input  wire logic [ACC_W-1:0]         PROD_IN,
  input  wire logic [WORD_W-1:0]        FIRST_POINTER_REG,
  input  wire logic [WORD_W-1:0]        SHIFT_VALUE_REG,
  input  wire logic                     SHIFT_MODE,
  output logic [ACC_W-1:0]              PRIMARY_ACC_ZERO,
  output logic [ACC_W-1:0]              PRIMARY_ACC_ONE,
  output logic [ACC_W-1:0]              SECONDARY_ACC_ZERO,
  output logic [ACC_W-1:0]              SECONDARY_ACC_ONE,
  output logic [WORD_W-1:0]             EXTREME_POINTER_REG,
  output aabs_flags_t                   FLAGS,
  output logic [WORD_W-1:0]             BUS_OUT,
  output logic                          BUS_OUT_VALID,
  output logic                          BUSY
);

  // Whole register state of the block.
  typedef struct packed {
    logic [3:0][ACC_W-1:0] acc;
    logic [WORD_W-1:0]     xptr;
    aabs_flags_t           flags;
    logic [WORD_W-1:0]     bus_out;
    logic                  bus_vld;
    logic                  rmw_busy;
    aabs_op_t              rmw_op;
    logic [WORD_W-1:0]     rmw_imm;
  } aabs_state_t;

  aabs_state_t state_ff;
  aabs_state_t nxt_state;

  logic [ACC_W-1:0]              sh_in;
  logic [ACC_W-1:0]              sh_out;
  logic                          sh_cout;
  logic signed [SAMT_W-1:0]      sh_amt;
  logic                          sh_rot;

  // Extends a bus operand of the given size to 36 bits.
  function automatic logic [ACC_W-1:0] extend(input logic [WORD_W-1:0] v,
                                              input aabs_size_t sz,
                                              input logic sgn);
    logic [ACC_W-1:0] r;
    r = '0;
    if (sz == SZ_8)
    begin
      r = {{(ACC_W-BYTE_W){sgn & v[BYTE_W-1]}}, v[BYTE_W-1:0]};
    end
    else
    begin
      r = {{(ACC_W-WORD_W){sgn & v[WORD_W-1]}}, v};
    end
    return r;
  endfunction

  // Flags of a 36-bit result.
  function automatic aabs_flags_t flags_of(input logic [ACC_W-1:0] v, input logic c);
    aabs_flags_t f;
    f.z = (v == '0);
    f.m = v[ACC_W-1];
    f.n = v[EXT_LSB-1] ^ v[EXT_LSB-2];
    f.e = (v[ACC_W-1:EXT_LSB-1] != '0) && (v[ACC_W-1:EXT_LSB-1] != '1);
    f.c = c;
    return f;
  endfunction

  // Conditional shift executes only when the decoder's condition holds.
  always_comb
  begin
    sh_in = state_ff.acc[CMD.src_acc];
    if (CMD.src2 == SRC_BUS)
    begin
      sh_in = (CMD.size == SZ_36) ? state_ff.acc[CMD.src_acc]
                                  : extend(BUS_IN, SZ_16, 1'b1);
    end
    sh_rot = 1'b0;
    sh_amt = '0;
    case (CMD.op)
      OP_SHIFT_I: sh_amt = SAMT_W'(CMD.imm_shift);
      OP_ROTATE:
      begin
        sh_amt = SAMT_W'(CMD.imm_shift);
        sh_rot = 1'b1;
      end
      OP_SHIFT_R:
      begin
        sh_amt = SAMT_W'($signed(SHIFT_VALUE_REG));
        if ($signed(SHIFT_VALUE_REG) > $signed(WORD_W'(SHV_MAX)))
        begin
          sh_amt = SHV_MAX;
        end
        else if ($signed(SHIFT_VALUE_REG) < $signed({{(WORD_W-SAMT_W){1'b1}}, SHV_MIN}))
        begin
          sh_amt = SHV_MIN;
        end
      end
      OP_MOD_SHL1: sh_amt = ONE_BIT;
      OP_MOD_SHR1: sh_amt = -ONE_BIT;
      OP_MOD_ROL1:
      begin
        sh_amt = ONE_BIT;
        sh_rot = 1'b1;
      end
      OP_MOD_ROR1:
      begin
        sh_amt = -ONE_BIT;
        sh_rot = 1'b1;
      end
      OP_MOD_SHL4: sh_amt = FOUR_BIT;
      OP_MOD_SHR4: sh_amt = -FOUR_BIT;
      default: sh_amt = '0;
    endcase
  end

  aabs_shifter u_shifter (
    .din    (sh_in),
    .amt    (sh_amt),
    .arith  (SHIFT_MODE),
    .rotate (sh_rot),
    .dout   (sh_out),
    .cout   (sh_cout)
  );

  // Next-state logic: ALU, loads, search, shifts and read-modify-write.
  always_comb
  begin
    logic [ACC_W-1:0] a;
    logic [ACC_W-1:0] b;
    logic [ACC_W:0]   sum;
    logic [ACC_W-1:0] res;
    logic [WORD_W:0]  wsum;
    logic             wr;
    logic             hit;
    logic [1:0]       other;
    nxt_state = state_ff;
    nxt_state.bus_vld = 1'b0;
    a = state_ff.acc[{1'b0, CMD.src_acc[0]}];
    other = {1'b0, ~CMD.src_acc[0]};
    b = '0;
    sum = '0;
    res = a;
    wsum = '0;
    wr = 1'b0;
    hit = 1'b0;
    // Second operand: product shifter, other accumulator or bus.
    case (CMD.src2)
      SRC_PROD: b = PROD_IN;
      SRC_ACC:  b = state_ff.acc[other];
      default:  b = extend(BUS_IN, CMD.size, !(CMD.op inside {OP_AND, OP_OR, OP_XOR}));
    endcase
    if (state_ff.rmw_busy)
    begin
      // Second cycle returns the word except for OP_CMP_RMW; accumulators stay put.
      wsum = (state_ff.rmw_op == OP_ADD_RMW)
             ? {1'b0, BUS_IN} + {1'b0, state_ff.rmw_imm}
             : {1'b0, BUS_IN} - {1'b0, state_ff.rmw_imm};
      nxt_state.bus_out = wsum[WORD_W-1:0];
      nxt_state.bus_vld = (state_ff.rmw_op != OP_CMP_RMW);
      nxt_state.flags = flags_of(extend(wsum[WORD_W-1:0], SZ_16, 1'b1), wsum[WORD_W]);
      nxt_state.rmw_busy = 1'b0;
    end
    else if (CMD.valid)
    begin
      case (CMD.op)
        OP_LOAD:
        begin
          res = (CMD.size == SZ_36) ? state_ff.acc[CMD.src_acc]
                                    : extend(BUS_IN, CMD.size, !CMD.no_ext);
          wr = 1'b1;
        end
        OP_LOAD_HI:
        begin
          res = {{EXT_W{!CMD.no_ext & BUS_IN[WORD_W-1]}}, BUS_IN, {WORD_W{1'b0}}};
          wr = 1'b1;
        end
        OP_LOAD_LO:
        begin
          res = {state_ff.acc[CMD.dst][ACC_W-1:EXT_LSB], {WORD_W{1'b0}}, BUS_IN};
          wr = 1'b1;
        end
        OP_LOAD_EX:
        begin
          res = {BUS_IN[EXT_W-1:0], state_ff.acc[CMD.dst][EXT_LSB-1:0]};
          wr = 1'b1;
        end
        OP_ADD, OP_SUB, OP_CMP:
        begin
          sum = (CMD.op == OP_ADD) ? {1'b0, a} + {1'b0, b} : {1'b0, a} - {1'b0, b};
          if (CMD.round_par)
          begin
            sum = sum + {1'b0, ROUND_CONST};
          end
          res = sum[ACC_W-1:0];
          wr = (CMD.op != OP_CMP);
          nxt_state.flags = flags_of(res, sum[ACC_W]);
        end
        // Logical operations span all 36 bits; a bus word arrives zero-extended.
        OP_AND:
        begin
          res = a & b;
          wr = 1'b1;
        end
        OP_OR:
        begin
          res = a | b;
          wr = 1'b1;
        end
        OP_XOR:
        begin
          res = a ^ b;
          wr = 1'b1;
        end
        OP_ROUND:
        begin
          sum = {1'b0, a} + {1'b0, ROUND_CONST};
          res = sum[ACC_W-1:0];
          wr = 1'b1;
        end
        OP_MAX, OP_MIN, OP_MAXMEM:
        begin
          // Held value sits in the named accumulator; candidate is the other or memory.
          a = state_ff.acc[{1'b0, CMD.dst[0]}];
          b = (CMD.op == OP_MAXMEM) ? extend(BUS_IN, SZ_16, 1'b1)
                                    : state_ff.acc[{1'b0, ~CMD.dst[0]}];
          if (CMD.op == OP_MIN)
          begin
            hit = CMD.or_equal ? ($signed(b) <= $signed(a)) : ($signed(b) < $signed(a));
          end
          else
          begin
            hit = CMD.or_equal ? ($signed(b) >= $signed(a)) : ($signed(b) > $signed(a));
          end
          if (hit)
          begin
            nxt_state.acc[{1'b0, CMD.dst[0]}] = b;
            nxt_state.xptr = FIRST_POINTER_REG;
          end
        end
        OP_SHIFT_I, OP_ROTATE, OP_SHIFT_R, OP_MOD_SHL1, OP_MOD_SHR1, OP_MOD_ROL1, OP_MOD_ROR1,
        OP_MOD_SHL4, OP_MOD_SHR4:
        begin
          // Only the destination changes, so a distinct source is kept.
          if (CMD.cond || (CMD.op inside {OP_SHIFT_I, OP_ROTATE}))
          begin
            nxt_state.acc[CMD.dst] = sh_out;
            nxt_state.flags = flags_of(sh_out, sh_cout);
          end
        end
        OP_SWAP: nxt_state.acc[CMD.dst] = state_ff.acc[CMD.src_acc];
        OP_ADD_RMW, OP_SUB_RMW, OP_CMP_RMW:
        begin
          nxt_state.rmw_busy = 1'b1;
          nxt_state.rmw_op = CMD.op;
          nxt_state.rmw_imm = CMD.imm;
        end
        default: wr = 1'b0;
      endcase
      if (wr)
      begin
        if (CMD.op inside {OP_LOAD, OP_LOAD_HI, OP_LOAD_LO, OP_LOAD_EX})
        begin
          nxt_state.acc[CMD.dst] = res;
        end
        else
        begin
          nxt_state.acc[{1'b0, CMD.src_acc[0]}] = res;
        end
        nxt_state.flags = flags_of(res, sum[ACC_W]);
      end
    end
  end

  // Registers the whole state.
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from registers.
  assign PRIMARY_ACC_ZERO    = state_ff.acc[0];
  assign PRIMARY_ACC_ONE     = state_ff.acc[1];
  assign SECONDARY_ACC_ZERO  = state_ff.acc[2];
  assign SECONDARY_ACC_ONE   = state_ff.acc[3];
  assign EXTREME_POINTER_REG = state_ff.xptr;
  assign FLAGS               = state_ff.flags;
  assign BUS_OUT             = state_ff.bus_out;
  assign BUS_OUT_VALID       = state_ff.bus_vld;
  assign BUSY                = state_ff.rmw_busy;

endmodule

// ### dv/aabs_chk.sv
`timescale 1ns/1ns
// Watches the datapath ports for timing and side-effect relations.
module aabs_chk
  import aabs_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire aabs_cmd_t         CMD,
  input wire logic [WORD_W-1:0] BUS_IN,
  input wire logic [ACC_W-1:0]  PRIMARY_ACC_ZERO,
  input wire logic [ACC_W-1:0]  PRIMARY_ACC_ONE,
  input wire logic [ACC_W-1:0]  SECONDARY_ACC_ONE,
  input wire logic [WORD_W-1:0] EXTREME_POINTER_REG,
  input wire logic              BUS_OUT_VALID,
  input wire logic              BUSY
);
  logic tk;
  logic rmw;
  // An instruction is taken only while the block is not busy.
  assign tk = CMD.valid && !BUSY;
  assign rmw = tk && (CMD.op inside {OP_ADD_RMW, OP_SUB_RMW, OP_CMP_RMW});
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_busy; rmw |=> BUSY ##1 !BUSY; endproperty
  a_busy: assert property (p_busy) else $error("busy is not one cycle");
  property p_valid; rmw && CMD.op != OP_CMP_RMW |-> ##2 BUS_OUT_VALID; endproperty
  a_valid: assert property (p_valid) else $error("no bus result");
  property p_cmp_immediate_rmw; tk && CMD.op == OP_CMP_RMW |-> ##2 !BUS_OUT_VALID; endproperty
  a_cmp_immediate_rmw: assert property (p_cmp_immediate_rmw) else $error("compare wrote the bus");
  property p_keep;
    rmw |-> ##3 ($past(tk) || PRIMARY_ACC_ZERO == $past(PRIMARY_ACC_ZERO, 3));
  endproperty
  a_keep: assert property (p_keep) else $error("rmw touched accumulator");
  property p_round;
    tk && CMD.op == OP_ROUND && !CMD.src_acc[0]
      |=> PRIMARY_ACC_ZERO == $past(PRIMARY_ACC_ZERO) + ROUND_CONST;
  endproperty
  a_round: assert property (p_round) else $error("rounding sum wrong");
  property p_alu;
    tk && CMD.op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR} && CMD.src_acc[0]
      |=> $stable(PRIMARY_ACC_ZERO);
  endproperty
  a_alu: assert property (p_alu) else $error("wrong alu destination");
  property p_swap;
    tk && CMD.op == OP_SWAP && CMD.dst == 2'h3 && CMD.src_acc == 2'h0
      |=> SECONDARY_ACC_ONE == $past(PRIMARY_ACC_ZERO);
  endproperty
  a_swap: assert property (p_swap) else $error("swap copy wrong");
  property p_src;
    tk && CMD.op == OP_SHIFT_I && CMD.src_acc == 2'h0 && CMD.dst != 2'h0
      |=> $stable(PRIMARY_ACC_ZERO);
  endproperty
  a_src: assert property (p_src) else $error("shift source changed");
  property p_nocond;
    tk && CMD.op == OP_SHIFT_R && !CMD.cond
      |=> $stable(PRIMARY_ACC_ZERO) && $stable(SECONDARY_ACC_ONE);
  endproperty
  a_nocond: assert property (p_nocond) else $error("untaken shift acted");
  property p_hi;
    tk && CMD.op == OP_LOAD_HI && CMD.dst == 2'h0 && !CMD.no_ext
      |=> PRIMARY_ACC_ZERO == {{4{$past(BUS_IN[15])}}, $past(BUS_IN), 16'h0000};
  endproperty
  a_hi: assert property (p_hi) else $error("high load wrong");
  property p_ptr;
    !(tk && CMD.op inside {OP_MAX, OP_MIN, OP_MAXMEM}) |=> $stable(EXTREME_POINTER_REG);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer moved");
  c_rmw: cover property (rmw);
  c_max: cover property (tk && CMD.op == OP_MAX);
  c_shr: cover property (tk && CMD.op == OP_SHIFT_R && CMD.cond);
endmodule
bind aabs_datapath aabs_chk u_chk (
  .CORE_CLK            (CORE_CLK),
  .RST                 (RST),
  .CMD                 (CMD),
  .BUS_IN              (BUS_IN),
  .PRIMARY_ACC_ZERO    (PRIMARY_ACC_ZERO),
  .PRIMARY_ACC_ONE     (PRIMARY_ACC_ONE),
  .SECONDARY_ACC_ONE   (SECONDARY_ACC_ONE),
  .EXTREME_POINTER_REG (EXTREME_POINTER_REG),
  .BUS_OUT_VALID       (BUS_OUT_VALID),
  .BUSY                (BUSY)
);

// ### dv/aabs_bus_model.sv
`timescale 1ns/1ns
// Data bus side: the memory word is offered only during the RMW read cycle.
module aabs_bus_model
  import aabs_pkg::*;
(
  input  wire logic [WORD_W-1:0] DEC_WORD,
  input  wire logic [WORD_W-1:0] MEM_WORD,
  input  wire logic              BUSY,
  output logic [WORD_W-1:0]      BUS_IN
);
  // Selects the memory word while the block waits for it.
  assign BUS_IN = BUSY ? MEM_WORD : DEC_WORD;
endmodule

// ### dv/accumulator_alu_barrel_shifter_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the accumulator, ALU and shifter datapath.
module accumulator_alu_barrel_shifter_tb_top import aabs_pkg::*;;
  logic              clk;
  logic              rst;
  aabs_cmd_t         cmd;
  logic [WORD_W-1:0] dec_word;
  logic [WORD_W-1:0] mem_word;
  logic [WORD_W-1:0] bus_in;
  logic [ACC_W-1:0]  prod;
  logic [WORD_W-1:0] ptr;
  logic [WORD_W-1:0] sv;
  logic              mode;
  logic [ACC_W-1:0]  a0;
  logic [ACC_W-1:0]  a1;
  logic [ACC_W-1:0]  b0;
  logic [ACC_W-1:0]  b1;
  logic [WORD_W-1:0] xptr;
  aabs_flags_t       flags;
  logic [WORD_W-1:0] bus_out;
  logic              bus_out_valid;
  logic              busy;
  int                num_errors;
  int                checked;
  int                cycles = 0;

  aabs_datapath uut (
    .CORE_CLK            (clk),
    .RST                 (rst),
    .CMD                 (cmd),
    .BUS_IN              (bus_in),
    .PROD_IN             (prod),
    .FIRST_POINTER_REG   (ptr),
    .SHIFT_VALUE_REG     (sv),
    .SHIFT_MODE          (mode),
    .PRIMARY_ACC_ZERO    (a0),
    .PRIMARY_ACC_ONE     (a1),
    .SECONDARY_ACC_ZERO  (b0),
    .SECONDARY_ACC_ONE   (b1),
    .EXTREME_POINTER_REG (xptr),
    .FLAGS               (flags),
    .BUS_OUT             (bus_out),
    .BUS_OUT_VALID       (bus_out_valid),
    .BUSY                (busy)
  );
  aabs_bus_model u_mem (
    .DEC_WORD (dec_word),
    .MEM_WORD (mem_word),
    .BUSY     (busy),
    .BUS_IN   (bus_in)
  );

  // Clock of 40 ns period.
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Ends the run with the counts and the verdict.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds reset for five cycles and restores default command fields.
  task automatic do_reset();
    rst = 1'h1;
    cmd = '0;
    cmd.size = SZ_16;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
  endtask

  // Issues one instruction and lets one idle edge pass.
  task automatic op(input aabs_op_t o, input logic [1:0] d, input logic [1:0] s,
                    input logic [WORD_W-1:0] w);
    cmd.op = o;
    cmd.dst = d;
    cmd.src_acc = s;
    dec_word = w;
    cmd.valid = 1'h1;
    @(negedge clk);
    cmd.valid = 1'h0;
    @(negedge clk);
  endtask

  task automatic t_load();
    do_reset();
    op(OP_LOAD_LO, 2'h0, 2'h0, 16'h1234);
    chk(a0, 36'h0_0000_1234);
    op(OP_LOAD_HI, 2'h0, 2'h0, 16'h8001);
    chk(a0, 36'hF_8001_0000);
    chk(flags.m, 1'h1);
    op(OP_LOAD_LO, 2'h0, 2'h0, 16'h5555);
    chk(a0, 36'hF_0000_5555);
    cmd.no_ext = 1'h1;
    op(OP_LOAD_HI, 2'h1, 2'h1, 16'h8001);
    chk(a1, 36'h0_8001_0000);
    $display("load test done");
  endtask

  task automatic t_alu();
    do_reset();
    op(OP_LOAD_LO, 2'h0, 2'h0, 16'h0010);
    op(OP_SUB, 2'h0, 2'h0, 16'h0020);
    chk(a0, 36'hF_FFFF_FFF0);
    op(OP_AND, 2'h0, 2'h0, 16'hFFFF);
    chk(a0, 36'h0_0000_FFF0);
    op(OP_OR, 2'h0, 2'h0, 16'h000F);
    op(OP_XOR, 2'h0, 2'h0, 16'h8000);
    chk(a0, 36'h0_0000_7FFF);
    cmd.src2 = SRC_PROD;
    prod = 36'h8_0000_0001;
    op(OP_ADD, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'h8_0000_8000);
    cmd.src2 = SRC_BUS;
    op(OP_ROUND, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'h8_0001_0000);
    op(OP_ADD, 2'h1, 2'h1, 16'h0005);
    cmd.size = SZ_8;
    op(OP_ADD, 2'h1, 2'h1, 16'h00FF);
    chk(a1, 36'h0_0000_0004);
    cmd.size = SZ_16;
    op(OP_SUB, 2'h1, 2'h1, 16'h0004);
    chk(a0, 36'h8_0001_0000);
    chk(flags.z, 1'h1);
    op(OP_CMP, 2'h1, 2'h1, 16'h0001);
    chk(a1, 36'h0_0000_0000);
    chk(flags.m, 1'h1);
    op(OP_LOAD_EX, 2'h1, 2'h1, 16'h000A);
    chk(a1, 36'hA_0000_0000);
    cmd.src2 = SRC_ACC;
    op(OP_OR, 2'h1, 2'h1, 16'h0000);
    chk(a1, 36'hA_0001_0000);
    cmd.src2 = SRC_BUS;
    cmd.round_par = 1'h1;
    op(OP_ADD, 2'h0, 2'h0, 16'h0001);
    chk(a0, 36'h8_0001_8001);
    cmd.round_par = 1'h0;
    cmd.size = SZ_8;
    op(OP_LOAD, 2'h1, 2'h1, 16'h0080);
    chk(a1, 36'hF_FFFF_FF80);
    cmd.size = SZ_16;
    $display("alu test done");
  endtask

  // One read-modify-write with the memory word fed by the bus model.
  task automatic rmw(input aabs_op_t o, input logic [WORD_W-1:0] exp, input logic v);
    op(o, 2'h0, 2'h0, 16'hAAAA);
    chk(bus_out_valid, v);
    if (v)
      chk(bus_out, exp);
    chk(a0, 36'h0_0000_0007);
  endtask

  task automatic t_rmw();
    do_reset();
    op(OP_LOAD_LO, 2'h0, 2'h0, 16'h0007);
    mem_word = 16'h1234;
    cmd.imm = 16'h0100;
    rmw(OP_ADD_RMW, 16'h1334, 1'h1);
    rmw(OP_SUB_RMW, 16'h1134, 1'h1);
    rmw(OP_CMP_RMW, 16'h0000, 1'h0);
    $display("rmw test done");
  endtask

  task automatic t_max();
    do_reset();
    op(OP_LOAD_LO, 2'h0, 2'h0, 16'h0005);
    op(OP_LOAD_LO, 2'h1, 2'h1, 16'h0009);
    ptr = 16'h0100;
    op(OP_MAX, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'h0_0000_0009);
    chk(xptr, 16'h0100);
    ptr = 16'h0101;
    op(OP_MAX, 2'h0, 2'h0, 16'h0000);
    chk(xptr, 16'h0100);
    cmd.or_equal = 1'h1;
    ptr = 16'h0102;
    op(OP_MAX, 2'h0, 2'h0, 16'h0000);
    chk(xptr, 16'h0102);
    cmd.or_equal = 1'h0;
    op(OP_LOAD_LO, 2'h1, 2'h1, 16'h0003);
    ptr = 16'h0103;
    op(OP_MIN, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'h0_0000_0003);
    chk(xptr, 16'h0103);
    ptr = 16'h0200;
    op(OP_MAXMEM, 2'h0, 2'h0, 16'h0020);
    chk(a0, 36'h0_0000_0020);
    chk(xptr, 16'h0200);
    $display("max test done");
  endtask

  task automatic t_shift();
    do_reset();
    op(OP_LOAD_HI, 2'h0, 2'h0, 16'h8001);
    mode = 1'h1;
    cmd.src2 = SRC_ACC;
    cmd.imm_shift = 6'h3C;
    op(OP_SHIFT_I, 2'h2, 2'h0, 16'h0000);
    chk(b0, 36'hF_F800_1000);
    chk(a0, 36'hF_8001_0000);
    mode = 1'h0;
    op(OP_SHIFT_I, 2'h2, 2'h0, 16'h0000);
    chk(b0, 36'h0_F800_1000);
    cmd.imm_shift = 6'h04;
    op(OP_SHIFT_I, 2'h2, 2'h0, 16'h0000);
    chk(b0, 36'h8_0010_0000);
    cmd.imm_shift = 6'h20;
    op(OP_SHIFT_I, 2'h2, 2'h0, 16'h0000);
    chk(b0, 36'h0_0000_000F);
    mode = 1'h1;
    sv = 16'hFFDC;
    op(OP_SHIFT_R, 2'h3, 2'h0, 16'h0000);
    chk(b1, 36'h0_0000_0000);
    cmd.cond = 1'h1;
    op(OP_SHIFT_R, 2'h3, 2'h0, 16'h0000);
    chk(b1, 36'hF_FFFF_FFFF);
    op(OP_MOD_ROL1, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'hF_0002_0001);
    op(OP_MOD_SHR4, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'hF_F000_2000);
    cmd.cond = 1'h0;
    op(OP_MOD_SHL1, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'hF_F000_2000);
    op(OP_SWAP, 2'h3, 2'h0, 16'h0000);
    chk(b1, 36'hF_F000_2000);
    cmd.imm_shift = 6'h04;
    op(OP_ROTATE, 2'h2, 2'h0, 16'h0000);
    chk(b0, 36'hF_0002_000F);
    cmd.cond = 1'h1;
    op(OP_MOD_SHL4, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'hF_0002_0000);
    op(OP_MOD_ROR1, 2'h0, 2'h0, 16'h0000);
    chk(a0, 36'h7_8001_0000);
    sv = 16'h0040;
    op(OP_SHIFT_R, 2'h3, 2'h0, 16'h0000);
    chk(b1, 36'h0_0000_0000);
    $display("shift test done");
  endtask

  // Main sequence.
  initial
  begin
    rst = 1'h1;
    cmd = '0;
    dec_word = 16'h0000;
    mem_word = 16'h0000;
    prod = 36'h0_0000_0000;
    ptr = 16'h0000;
    sv = 16'h0000;
    mode = 1'h1;
    num_errors = 0;
    checked = 0;
    t_load();
    t_alu();
    t_rmw();
    t_max();
    t_shift();
    test_done();
  end
endmodule
